// ### rtl/inverter_link_defines.vh
`ifndef INVERTER_LINK_DEFINES_VH
`define INVERTER_LINK_DEFINES_VH

// register byte offsets
`define REG_CTRL        8'h00
`define REG_AC_STAT     8'h04
`define REG_INV_STAT    8'h08
`define REG_LOAD_BATT   8'h0C
`define REG_STATUS      8'h10
`define REG_INT_STAT    8'h14
`define REG_INT_MASK    8'h18

// reset values and field layout
`define BAUD_SEL_DEFAULT 3'h3
`define BAUD_SEL_MAX     3'h4
`define AC_STAT_USED     8'hDA
`define INV_STAT_USED    8'hF7
`define AC_FREQ_OK_BIT   7
`define INV_OTP_BIT      4
`define INV_OLP_BIT      2
`define INV_OVP_BIT      1
`define INV_UVP_BIT      0
`define EV_CMD_OK        0
`define EV_CMD_DROP      1
`define EV_REPLY_DONE    2
`define EV_FRAME_ERR     3
`define EV_WIDTH         4

// baud rates selected by codes 0 to 4
`define BAUD_0 1200
`define BAUD_1 2400
`define BAUD_2 4800
`define BAUD_3 9600
`define BAUD_4 19200

// characters and query texts
`define CHAR_CR     8'h0D
`define CHAR_LF     8'h0A
`define CMD_LEN     4'h7
`define LEN_POISON  4'hF
`define CMD_AC      56'h5155525920303F
`define CMD_LOAD    56'h5155525920313F
`define CMD_INV     56'h5155525920323F
`define HEX_DIGIT0  8'h30
`define HEX_ALPHA_A 8'h37
`define REPLY_LAST  2'h3

// indicator timing in milliseconds, as counter bits
`define MS_CNT_W      11
`define BLINK_FAST_B  7
`define BLINK_SLOW_B  9
`define BLINK_GAP_B   10

`endif

// ### rtl/serial_rx.v
`timescale 1ns/10ps
`default_nettype none
module serial_rx (
  // clock and reset
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        ce,
  // bit timing
  input  wire [15:0] divisor,
  // line and received byte
  input  wire        rxd,
  output reg  [7:0]  data_q,
  output reg         valid_q,
  output reg         frame_err_q
);
  reg [15:0] cnt_q;
  reg [3:0]  bit_q;
  reg        busy_q;
  reg [7:0]  sh_q;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q       <= 16'h0000;
      bit_q       <= 4'h0;
      busy_q      <= 1'b0;
      sh_q        <= 8'h00;
      data_q      <= 8'h00;
      valid_q     <= 1'b0;
      frame_err_q <= 1'b0;
    end else if (ce) begin
      valid_q     <= 1'b0;
      frame_err_q <= 1'b0;
      if (!busy_q) begin
        if (!rxd) begin
          // first sample lands in the middle of the start bit
          busy_q <= 1'b1;
          bit_q  <= 4'h0;
          cnt_q  <= {1'b0, divisor[15:1]};
        end
      end else if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end else begin
        cnt_q <= divisor - 16'h0001;
        bit_q <= bit_q + 4'h1;
        if (bit_q == 4'h0) begin
          if (rxd) busy_q <= 1'b0;
        end else if (bit_q == 4'h9) begin
          busy_q <= 1'b0;
          if (rxd) begin
            data_q  <= sh_q;
            valid_q <= 1'b1;
          end else begin
            frame_err_q <= 1'b1;
          end
        end else begin
          sh_q <= {rxd, sh_q[7:1]};
        end
      end
    end
  end
endmodule // serial_rx
`default_nettype wire

// ### rtl/serial_tx.v
`timescale 1ns/10ps
`default_nettype none
module serial_tx (
  // clock and reset
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        ce,
  // bit timing
  input  wire [15:0] divisor,
  // byte request
  input  wire        start,
  input  wire [7:0]  data,
  output wire        ready,
  // line
  output reg         txd_q
);
  reg [15:0] cnt_q;
  reg [3:0]  bit_q;
  reg        busy_q;
  reg [8:0]  sh_q;

  assign ready = !busy_q;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q  <= 16'h0000;
      bit_q  <= 4'h0;
      busy_q <= 1'b0;
      sh_q   <= 9'h1FF;
      txd_q  <= 1'b1;
    end else if (ce) begin
      if (!busy_q) begin
        if (start) begin
          // start bit, eight data bits lsb first, one stop bit
          busy_q <= 1'b1;
          txd_q  <= 1'b0;
          sh_q   <= {1'b1, data};
          bit_q  <= 4'h0;
          cnt_q  <= divisor - 16'h0001;
        end
      end else if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end else if (bit_q == 4'h9) begin
        busy_q <= 1'b0;
      end else begin
        txd_q  <= sh_q[0];
        sh_q   <= {1'b1, sh_q[8:1]};
        bit_q  <= bit_q + 4'h1;
        cnt_q  <= divisor - 16'h0001;
      end
    end
  end
endmodule // serial_tx
`default_nettype wire

// ### rtl/inverter_ascii_status_link.v
`timescale 1ns/10ps
`default_nettype none
`include "inverter_link_defines.vh"
// Contract
// - every command and reply ends with carriage return then line feed
// - link defaults to 9600 baud, eight data bits, no parity, one stop bit
// - host parameters are integers; replies are ascii integer, hex or real text
// - ac status query gets two status characters plus terminator
// - each status character is one hex digit; first flag is its msb
// - first ac digit: freq ok, ac/dc source, reserved, processor supply fault
// - second ac digit: soft reset, inverter damage, grid voltage ok, reserved; the code masks the inverter damage bit to zero
// - load and battery reply: load in ten-percent bands, then scaled battery level
// - first inverter digit: overload, overvoltage, undervoltage alarms, over-temperature
// - second inverter digit: reserved, overload, input overvoltage, input undervoltage protect
// - over-temperature protection gives intermittent red blinking
// - input overvoltage protection gives fast red blinking
// - input undervoltage protection gives slow red blinking
// - ac source not synchronized gives intermittent red blinking
// - short circuit or overload keeps the red indicator solid on
// - baud codes 0 to 4 select 1200, 2400, 4800, 9600, 19200
module inverter_ascii_status_link #(
  parameter CLK_HZ       = 50000000,
  parameter CYCLES_PER_MS = 50000
) (
  // clock, reset, enable
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        ce,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // serial link
  input  wire        rxd,
  output wire        txd,
  // indicator and interrupt
  output reg         red_led,
  output wire        irq
);
  // host commands are bare ascii text; no integer parameter is needed here

  // baud divisors, cut to the bit-timer width
  localparam integer DIV_0 = CLK_HZ / `BAUD_0;
  localparam integer DIV_1 = CLK_HZ / `BAUD_1;
  localparam integer DIV_2 = CLK_HZ / `BAUD_2;
  localparam integer DIV_3 = CLK_HZ / `BAUD_3;
  localparam integer DIV_4 = CLK_HZ / `BAUD_4;

  function [15:0] baud_div;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    baud_div = DIV_0[15:0];
        3'h1:    baud_div = DIV_1[15:0];
        3'h2:    baud_div = DIV_2[15:0];
        3'h3:    baud_div = DIV_3[15:0];
        3'h4:    baud_div = DIV_4[15:0];
        default: baud_div = DIV_3[15:0];
      endcase
    end
  endfunction

  // one nibble to an upper-case ascii hex character
  function [7:0] hex_char;
    input [3:0] nib;
    begin
      if (nib < 4'hA)
        hex_char = `HEX_DIGIT0 + {4'h0, nib};
      else
        hex_char = `HEX_ALPHA_A + {4'h0, nib};
    end
  endfunction

  // status byte to two hex digits and the line terminator
  function [31:0] reply_word;
    input [7:0] v;
    begin
      reply_word = {hex_char(v[7:4]), hex_char(v[3:0]), `CHAR_CR, `CHAR_LF};
    end
  endfunction

  function reg_hit;
    input [7:0] a;
    begin
      reg_hit = (a == `REG_CTRL) || (a == `REG_AC_STAT) || (a == `REG_INV_STAT) ||
                (a == `REG_LOAD_BATT) || (a == `REG_STATUS) ||
                (a == `REG_INT_STAT) || (a == `REG_INT_MASK);
    end
  endfunction

  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;
  // last query kinds shown in status
  localparam [1:0] LAST_AC   = 2'h1;
  localparam [1:0] LAST_LOAD = 2'h2;
  localparam [1:0] LAST_INV  = 2'h3;

  // software registers
  reg  [2:0]  baud_sel_q;
  reg  [7:0]  ac_stat_q;
  reg  [7:0]  inv_stat_q;
  reg  [7:0]  load_batt_q;
  reg  [`EV_WIDTH-1:0] int_stat_q;
  reg  [`EV_WIDTH-1:0] int_stat_d;
  reg  [`EV_WIDTH-1:0] int_mask_q;
  // receive parser
  reg  [55:0] line_q;
  reg  [3:0]  len_q;
  reg         cr_q;
  reg  [1:0]  last_cmd_q;
  // reply engine
  reg         state_q;
  reg  [31:0] reply_q;
  reg  [1:0]  idx_q;
  // indicator timing
  reg  [15:0] pre_q;
  reg  [`MS_CNT_W-1:0] ms_q;

  wire [15:0] divisor;
  wire [7:0]  rx_data;
  wire        rx_valid;
  wire        rx_ferr;
  wire        tx_ready;
  wire        tx_start;
  wire        setup;
  wire        access;
  wire        wr_en;
  wire        rd_stat;
  wire        got_line;
  wire        cmd_ac;
  wire        cmd_load;
  wire        cmd_inv;
  wire        cmd_known;
  wire        cmd_take;
  wire        cmd_drop;
  wire        reply_done;
  wire        led_solid;
  wire        led_fast;
  wire        led_slow;
  wire        led_inter;
  wire        led_d;
  wire        ms_tick;
  wire        lf_seen;
  wire [7:0]  status_bits;

  assign divisor = baud_div(baud_sel_q);

  serial_rx u_rx (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .ce          (ce),
    .divisor     (divisor),
    .rxd         (rxd),
    .data_q      (rx_data),
    .valid_q     (rx_valid),
    .frame_err_q (rx_ferr)
  );

  serial_tx u_tx (
    .core_clk (core_clk),
    .resetn   (resetn),
    .ce       (ce),
    .divisor  (divisor),
    .start    (tx_start),
    .data     (reply_q[31:24]),
    .ready    (tx_ready),
    .txd_q    (txd)
  );

  // apb decode: zero wait states, read data captured in the setup cycle
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign pready  = 1'b1;
  assign pslverr = access && !reg_hit(paddr);
  assign wr_en   = ce && access && pwrite;
  assign rd_stat = ce && access && !pwrite && (paddr == `REG_INT_STAT);
  // status word for software
  assign status_bits = {red_led, !tx_ready, state_q, cr_q, (len_q == 4'h0), 1'b0, last_cmd_q};

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (ce && setup) begin
      case (paddr)
        `REG_CTRL:      prdata <= {29'h0, baud_sel_q};
        `REG_AC_STAT:   prdata <= {24'h0, ac_stat_q};
        `REG_INV_STAT:  prdata <= {24'h0, inv_stat_q};
        `REG_LOAD_BATT: prdata <= {24'h0, load_batt_q};
        `REG_STATUS:    prdata <= {24'h0, status_bits};
        `REG_INT_STAT:  prdata <= {28'h0, int_stat_q};
        `REG_INT_MASK:  prdata <= {28'h0, int_mask_q};
        default:        prdata <= 32'h00000000;
      endcase
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      baud_sel_q  <= `BAUD_SEL_DEFAULT;
      ac_stat_q   <= 8'h00;
      inv_stat_q  <= 8'h00;
      load_batt_q <= 8'h00;
      int_mask_q  <= {`EV_WIDTH{1'b0}};
    end else if (wr_en) begin
      case (paddr)
        `REG_CTRL: begin
          if (pwdata[2:0] <= `BAUD_SEL_MAX) baud_sel_q <= pwdata[2:0];
        end
        `REG_AC_STAT:   ac_stat_q   <= pwdata[7:0] & `AC_STAT_USED;
        `REG_INV_STAT:  inv_stat_q  <= pwdata[7:0] & `INV_STAT_USED;
        `REG_LOAD_BATT: load_batt_q <= pwdata[7:0];
        `REG_INT_MASK:  int_mask_q  <= pwdata[`EV_WIDTH-1:0];
        default:        int_mask_q  <= int_mask_q;
      endcase
    end
  end

  // line parser: act only on cr then lf after exactly the query text
  assign lf_seen   = rx_valid && (rx_data == `CHAR_LF);
  assign got_line  = lf_seen && cr_q && (len_q == `CMD_LEN);
  assign cmd_ac    = (line_q == `CMD_AC);
  assign cmd_load  = (line_q == `CMD_LOAD);
  assign cmd_inv   = (line_q == `CMD_INV);
  assign cmd_known = cmd_ac || cmd_load || cmd_inv;
  assign cmd_take  = got_line && cmd_known && (state_q == ST_IDLE);
  assign cmd_drop  = lf_seen && !cmd_take;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      line_q     <= 56'h0;
      len_q      <= 4'h0;
      cr_q       <= 1'b0;
      last_cmd_q <= 2'h0;
    end else if (ce && rx_valid) begin
      if (rx_data == `CHAR_LF) begin
        len_q <= 4'h0;
        cr_q  <= 1'b0;
        if (cmd_take) last_cmd_q <= cmd_ac ? LAST_AC : (cmd_load ? LAST_LOAD : LAST_INV);
      end else if (rx_data == `CHAR_CR) begin
        cr_q <= 1'b1;
      end else begin
        line_q <= {line_q[47:0], rx_data};
        cr_q   <= 1'b0;
        if (cr_q || len_q == `LEN_POISON)
          len_q <= `LEN_POISON;
        else
          len_q <= len_q + 4'h1;
      end
    end
  end

  // reply engine: two hex digits, carriage return, line feed
  assign tx_start   = (state_q == ST_SEND) && tx_ready;
  assign reply_done = tx_start && (idx_q == `REPLY_LAST);

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      reply_q <= 32'h00000000;
      idx_q   <= 2'h0;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_take) begin
            state_q <= ST_SEND;
            idx_q   <= 2'h0;
            if (cmd_ac)
              reply_q <= reply_word(ac_stat_q);
            else if (cmd_load)
              reply_q <= reply_word(load_batt_q);
            else
              reply_q <= reply_word(inv_stat_q);
          end
        end
        ST_SEND: begin
          if (tx_start) begin
            reply_q <= {reply_q[23:0], 8'h00};
            idx_q   <= idx_q + 2'h1;
            if (idx_q == `REPLY_LAST) state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // interrupt status: a read clears only the bits it returned; set wins
  always @* begin
    int_stat_d = int_stat_q & ~(rd_stat ? prdata[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}});
    int_stat_d[`EV_CMD_OK]     = int_stat_d[`EV_CMD_OK] | cmd_take;
    int_stat_d[`EV_CMD_DROP]   = int_stat_d[`EV_CMD_DROP] | cmd_drop;
    int_stat_d[`EV_REPLY_DONE] = int_stat_d[`EV_REPLY_DONE] | reply_done;
    int_stat_d[`EV_FRAME_ERR]  = int_stat_d[`EV_FRAME_ERR] | rx_ferr;
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      int_stat_q <= {`EV_WIDTH{1'b0}};
    else if (ce)
      int_stat_q <= int_stat_d;
  end

  assign irq = |(int_stat_q & int_mask_q);

  // millisecond timebase for the indicator
  assign ms_tick = (pre_q == CYCLES_PER_MS[15:0] - 16'h0001);

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= 16'h0000;
      ms_q  <= {`MS_CNT_W{1'b0}};
    end else if (ce) begin
      if (ms_tick) begin
        pre_q <= 16'h0000;
        ms_q  <= ms_q + {{(`MS_CNT_W-1){1'b0}}, 1'b1};
      end else begin
        pre_q <= pre_q + 16'h0001;
      end
    end
  end

  // indicator priority: solid, fast, slow, intermittent
  assign led_solid = inv_stat_q[`INV_OLP_BIT];
  assign led_fast  = inv_stat_q[`INV_OVP_BIT];
  assign led_slow  = inv_stat_q[`INV_UVP_BIT];
  assign led_inter = inv_stat_q[`INV_OTP_BIT] || !ac_stat_q[`AC_FREQ_OK_BIT];
  assign led_d = led_solid ? 1'b1 :
                 led_fast  ? ms_q[`BLINK_FAST_B] :
                 led_slow  ? ms_q[`BLINK_SLOW_B] :
                 led_inter ? (ms_q[`BLINK_FAST_B] && !ms_q[`BLINK_GAP_B]) : 1'b0;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      red_led <= 1'b0;
    else if (ce)
      red_led <= led_d;
  end
endmodule // inverter_ascii_status_link
`default_nettype wire

// ### testbench/link_checker_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module link_checker (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        ce,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // link, indicator, interrupt
  input wire logic        txd,
  input wire logic        red_led,
  input wire logic        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic acc;
  logic mask_nz_q;
  assign acc = psel && penable && ce;
  // remembers whether any mask bit is set
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mask_nz_q <= 1'b0;
    end else if (acc && pwrite && paddr == 8'h18) begin
      mask_nz_q <= |pwdata[3:0];
    end
  end
  a_no_wait: assert property (acc |-> pready)
    else $error("access without ready");
  a_unmapped_err: assert property (acc && paddr > 8'h18 |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (acc && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access flagged");
  a_err_reads_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_read_holds: assert property (acc && !pwrite |=> $stable(prdata))
    else $error("read data moved");
  a_start_bit_len: assert property ($fell(txd) |-> !txd [*4])
    else $error("start bit too short");
  a_mask_gates_irq: assert property (irq |-> mask_nz_q)
    else $error("irq with empty mask");
  a_mask_clear_irq: assert property (acc && pwrite && paddr == 8'h18 && pwdata[3:0] == 4'h0
    |=> !irq)
    else $error("irq after mask cleared");
  a_led_off_reset: assert property ($rose(resetn) |-> !red_led)
    else $error("indicator lit out of reset");
  cover property (acc && pwrite);
  cover property ($fell(txd));
  cover property (irq);
  cover property ($rose(red_led));
endmodule // link_checker
bind inverter_ascii_status_link link_checker u_chk (.core_clk(core_clk), .resetn(resetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .txd(txd), .red_led(red_led),
  .irq(irq));
`default_nettype wire

// ### testbench/line_host.sv
`timescale 1ns/10ps
`default_nettype none
module line_host (
  // clock
  input wire logic core_clk,
  // serial lines
  input wire logic txd,
  output var logic rxd
);
  int         div = 10;
  logic [7:0] got[$];
  initial rxd = 1'b1;
  task automatic put_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (div) @(posedge core_clk);
    end
  endtask
  task automatic send_line(input logic [55:0] t);
    for (int i = 6; i >= 0; i--) begin
      put_byte(t[i*8 +: 8]);
    end
    put_byte(8'h0D);
    put_byte(8'h0A);
  endtask
  // collects reply bytes sampled mid-bit, keeps those with a high stop bit
  always begin
    logic [7:0] b;
    @(negedge txd);
    repeat (div / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge core_clk);
      b[i] = txd;
    end
    repeat (div) @(posedge core_clk);
    if (txd) got.push_back(b);
  end
endmodule // line_host
`default_nettype wire

// ### testbench/test_inverter_ascii_status_link.sv
`timescale 1ns/10ps
`default_nettype none
`include "inverter_link_defines.vh"
module test_inverter_ascii_status_link;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rv;
  logic        err;
  wire         pready, pslverr, txd, red_led, irq, rxd;
  wire  [31:0] prdata;
  int          mismatches = 0;
  int          tests_run = 0;
  always #10 core_clk = ~core_clk;
  inverter_ascii_status_link #(.CLK_HZ(96000), .CYCLES_PER_MS(10)) dut (.core_clk(core_clk),
    .resetn(resetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .rxd(rxd),
    .txd(txd), .red_led(red_led), .irq(irq));
  line_host host (.core_clk(core_clk), .txd(txd), .rxd(rxd));
  task check(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    check(n, e, rv);
  endtask
  function logic [7:0] hexc(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
  endfunction
  task query(input logic [55:0] t, input logic [7:0] v);
    int n;
    host.got.delete();
    host.send_line(t);
    n = 0;
    while (host.got.size() < 4 && n < 60 * host.div) begin
      @(posedge core_clk);
      n++;
    end
    check("reply bytes", 4, host.got.size());
    check("reply", {hexc(v[7:4]), hexc(v[3:0]), 8'h0D, 8'h0A},
      {host.got[0], host.got[1], host.got[2], host.got[3]});
  endtask
  task led_run(input int cyc, output int tr, output int hi);
    logic p;
    tr = 0;
    hi = 0;
    p = red_led;
    repeat (cyc) begin
      @(posedge core_clk);
      tr += (red_led !== p);
      hi += red_led;
      p = red_led;
    end
  endtask
  task t_reset;
    rd(`REG_CTRL, 32'h3, "baud code");
    rd(`REG_INV_STAT, 32'h0, "inverter status");
    rd(8'h1C, 32'h0, "unmapped read");
    check("unmapped error", 1, err);
    ce <= 1'b0;
    apb(1'b1, `REG_AC_STAT, 32'hFF);
    ce <= 1'b1;
    rd(`REG_AC_STAT, 32'h0, "frozen write");
    $display("test reset done");
  endtask
  task t_queries;
    apb(1'b1, `REG_AC_STAT, 32'hFF);
    rd(`REG_AC_STAT, 32'hDA, "ac reserved");
    query(`CMD_AC, 8'hDA);
    apb(1'b1, `REG_INV_STAT, 32'h2F);
    query(`CMD_INV, 8'h27);
    apb(1'b1, `REG_LOAD_BATT, 32'h56);
    query(`CMD_LOAD, 8'h56);
    $display("test queries done");
  endtask
  task t_drop_irq;
    logic [55:0] bad;
    bad = `CMD_AC;
    bad[15:8] = 8'h39;
    apb(1'b0, `REG_INT_STAT, 32'h0);
    apb(1'b1, `REG_INT_MASK, 32'h2);
    host.got.delete();
    host.send_line(bad);
    repeat (600) @(posedge core_clk);
    check("no reply", 0, host.got.size());
    check("irq raised", 1, irq);
    rd(`REG_INT_STAT, 32'h2, "drop event");
    check("irq cleared", 0, irq);
    apb(1'b1, `REG_INT_MASK, 32'h0);
    $display("test drop done");
  endtask
  task t_baud;
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, `REG_CTRL, c);
      host.div = 80 >> c;
      query(`CMD_LOAD, 8'h56);
    end
    apb(1'b1, `REG_CTRL, 32'h7);
    rd(`REG_CTRL, 32'h4, "refused code");
    apb(1'b1, `REG_CTRL, 32'h3);
    host.div = 10;
    $display("test baud done");
  endtask
  task t_led;
    int tr;
    int hi;
    apb(1'b1, `REG_AC_STAT, 32'h80);
    apb(1'b1, `REG_INV_STAT, 32'h04);
    led_run(2000, tr, hi);
    check("solid on", 2000, hi);
    apb(1'b1, `REG_INV_STAT, 32'h02);
    led_run(5120, tr, hi);
    check("fast blink", 1, tr >= 3);
    apb(1'b1, `REG_INV_STAT, 32'h01);
    led_run(5120, tr, hi);
    check("slow blink", 1, tr > 0 && tr <= 2);
    apb(1'b1, `REG_INV_STAT, 32'h10);
    led_run(20480, tr, hi);
    check("temperature blink", 5120, hi);
    apb(1'b1, `REG_INV_STAT, 32'h00);
    apb(1'b1, `REG_AC_STAT, 32'h00);
    led_run(20480, tr, hi);
    check("unsynchronized blink", 5120, hi);
    apb(1'b1, `REG_AC_STAT, 32'h80);
    led_run(200, tr, hi);
    check("indicator off", 0, hi);
    $display("test indicator done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (99000) @(posedge core_clk);
    mismatches++;
    $display("watchdog expired");
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_reset;
    t_queries;
    t_drop_irq;
    t_baud;
    t_led;
    tally_and_finish;
  end
endmodule // test_inverter_ascii_status_link
`default_nettype wire
